// [rtl/bsf_params.svh]
// Constants of the boot failure status block
`ifndef BSF_PARAMS_SVH
`define BSF_PARAMS_SVH

// Serial opcodes
`define BSF_OP_NONE    8'h00
`define BSF_OP_RDSR1   8'h05
`define BSF_OP_RDARG   8'h65
`define BSF_OP_WREN    8'h06
`define BSF_OP_WRARG   8'h71

// Register addresses
`define BSF_ADR_VSTAT  32'h0080_0000
`define BSF_ADR_NVBASE 32'h0000_0000
`define BSF_NV_COUNT   6
`define BSF_STAT_IDX   3'h0
`define BSF_OCT_IDX    3'h2
`define BSF_CFG5_IDX   3'h5

// Volatile status field positions and octal enable bit
`define BSF_BIT_BUSY   0
`define BSF_BIT_WEL    1
`define BSF_BP_LSB     2
`define BSF_BP_MSB     4
`define BSF_BIT_ERS    5
`define BSF_BIT_PRG    6
`define BSF_BIT_RSV    7
`define BSF_OCT_BIT    0

// Reset values
`define BSF_NV_RST     8'h00
`define BSF_CFG5_RST   8'h40

// Frame timing: opcode bits, address bytes and latency in link clock cycles
`define BSF_OP_BITS    8
`define BSF_ADDR_BYTES 4
`define BSF_RD_LAT     2

`endif

// [rtl/bsf_pkg.sv]
// Types of the boot failure status block
package bsf_pkg;

  typedef enum logic [1:0] {
    BSF_BOOTING,
    BSF_RUNNING,
    BSF_FAILED
  } bsf_state_e;

  typedef enum logic [1:0] {
    BSF_CMD_NONE,
    BSF_CMD_WEN,
    BSF_CMD_WRITE
  } bsf_cmd_e;

  typedef logic [7:0]  bsf_byte_t;
  typedef logic [31:0] bsf_addr_t;
  typedef logic [2:0]  bsf_bp_t;

endpackage : bsf_pkg

// [rtl/bsf_stat_if.sv]
// Carrier between the core and the status keeper
`timescale 1ns/100ps
interface bsf_stat_if;
  import bsf_pkg::*;

  bsf_bp_t   bpSize;
  logic      wel;
  bsf_byte_t statusByte;
  logic      failed;

  modport status (
    input  bpSize,
    input  wel,
    output statusByte,
    output failed
  );

  modport core (
    output bpSize,
    output wel,
    input  statusByte,
    input  failed
  );
endinterface : bsf_stat_if

// [rtl/bsf_status.sv]
// Initialisation tracker and volatile status composer
`timescale 1ns/100ps
`include "bsf_params.svh"
module bsf_status (
  input  wire logic    clk_sys,
  input  wire logic    resetn,
  input  wire logic    initDone,
  input  wire logic    initFail,
  bsf_stat_if.status   st
);
  import bsf_pkg::*;

  bsf_state_e state_r;
  bsf_state_e state_nxt;
  bsf_byte_t  status_r;
  bsf_byte_t  status_nxt;
  logic       failed_r;

  // Failure sticks until hardware reset
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      BSF_BOOTING: begin
        if (initFail) begin
          state_nxt = BSF_FAILED;
        end else if (initDone) begin
          state_nxt = BSF_RUNNING;
        end
      end
      BSF_RUNNING: state_nxt = BSF_RUNNING;
      BSF_FAILED:  state_nxt = BSF_FAILED; // RL13
      default:     state_nxt = BSF_BOOTING;
    endcase
  end

  wire isFailed  = (state_nxt == BSF_FAILED);
  wire isBooting = (state_nxt == BSF_BOOTING);

  // Status byte
  always_comb begin
    status_nxt                          = 8'h00;
    status_nxt[`BSF_BP_MSB:`BSF_BP_LSB] = st.bpSize; // RL7
    status_nxt[`BSF_BIT_RSV]            = 1'b0; // RL6
    if (isFailed) begin
      status_nxt[`BSF_BIT_PRG]  = 1'b1; // RL2
      status_nxt[`BSF_BIT_ERS]  = 1'b1; // RL3
      status_nxt[`BSF_BIT_BUSY] = 1'b1; // RL4
      status_nxt[`BSF_BIT_WEL]  = 1'b0; // RL5
    end else begin
      status_nxt[`BSF_BIT_PRG]  = 1'b0; // RL16
      status_nxt[`BSF_BIT_ERS]  = 1'b0; // RL16
      status_nxt[`BSF_BIT_BUSY] = isBooting;
      status_nxt[`BSF_BIT_WEL]  = st.wel;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r  <= BSF_BOOTING;
      status_r <= 8'h01;
      failed_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      status_r <= status_nxt;
      failed_r <= isFailed;
    end
  end

  assign st.statusByte = status_r;
  assign st.failed     = failed_r;

endmodule : bsf_status

// [rtl/bsf_top.sv]
// Boot failure status block with serial register link
`timescale 1ns/100ps
`include "bsf_params.svh"
// How it works
// RL1 - On controller init failure, fall back to single-lane link and show failure signature.
// RL2 - Failure signature reports program error flag as one.
// RL3 - Failure signature reports erase error flag as one too.
// RL4 - Failure signature holds busy flag at one while failure lasts.
// RL5 - Failure signature reports write enable latch as zero.
// RL6 - Failure signature reads reserved bit seven as zero.
// RL7 - Block protect size bits follow the held protection configuration.
// RL8 - In failure only status read and read-any-register are accepted.
// RL9 - Failure register reads use four address bytes and two latency cycles.
// RL10 - Host must address the volatile status; nonvolatile address gives undefined data.
// RL11 - Host polls status and compares against the failure signature.
// RL12 - Host polls widest mode first, stepping down to single lane. The host model polls in single lane only.
// RL13 - Host recovers a failed device with a hardware reset.
// RL14 - First nonvolatile write resets other nonvolatile registers; config five becomes 0x40.
// RL15 - Host should restore address length and latency before other settings.
// RL16 - A healthy device never shows both error flags together.
module bsf_top #(
  parameter int NvCount   = `BSF_NV_COUNT,
  parameter int AddrBytes = `BSF_ADDR_BYTES,
  parameter int RdLat     = `BSF_RD_LAT
) (
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  input  wire logic          mcuInitDone,
  input  wire logic          mcuInitFail,
  input  wire logic          linkClk,
  input  wire logic          linkCsN,
  input  wire logic          linkSi,
  output logic               linkSo,
  output logic               linkSoEn,
  output logic               bootFailed,
  output logic               singleLaneMode,
  output bsf_pkg::bsf_byte_t statusView
);
  import bsf_pkg::*;

  localparam logic [6:0] OpLast   = 7'(`BSF_OP_BITS - 1);
  localparam logic [6:0] AddrLast = 7'(`BSF_OP_BITS + 8 * AddrBytes - 1);
  localparam logic [6:0] RdStart  = 7'(`BSF_OP_BITS + 8 * AddrBytes + RdLat);
  localparam logic [6:0] WrLast   = 7'(`BSF_OP_BITS + 8 * AddrBytes + 7);
  localparam logic [6:0] CntMax   = 7'(`BSF_OP_BITS + 8 * AddrBytes + 8);

  // Nonvolatile address decode: hit flag and index
  function automatic logic [3:0] nvDecode(input bsf_addr_t adr);
    bsf_addr_t off;
    off = adr - `BSF_ADR_NVBASE;
    nvDecode = {(off < 32'(NvCount)), off[2:0]};
  endfunction : nvDecode

  // Predefined value of a nonvolatile register
  function automatic bsf_byte_t nvDefault(input logic [2:0] idx);
    nvDefault = (idx == `BSF_CFG5_IDX) ? `BSF_CFG5_RST : `BSF_NV_RST;
  endfunction : nvDefault

  bsf_stat_if st ();

  bsf_status u_status (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .initDone (mcuInitDone),
    .initFail (mcuInitFail),
    .st       (st.status)
  );

  // Registers published to the link, frozen while a frame is open
  bsf_byte_t statusPub_r;
  bsf_byte_t nvPub_r [NvCount];
  logic      failPub_r;

  // Link domain
  logic [6:0]  bitCnt_r;
  logic [30:0] shift_r;
  bsf_byte_t   opCode_r;
  bsf_addr_t   addr_r;
  logic        cmdTgl_r;
  bsf_cmd_e    cmdKind_r;
  bsf_addr_t   cmdAddr_r;
  bsf_byte_t   cmdData_r;
  logic        so_r;
  logic        soEn_r;
  logic [2:0]  bitIdx_r;

  wire bsf_byte_t opIn      = {shift_r[6:0], linkSi};
  wire bsf_addr_t addrIn    = {shift_r, linkSi};
  wire            opEnd     = (bitCnt_r == OpLast);
  wire            addrEnd   = (bitCnt_r == AddrLast);
  wire            wrEnd     = (bitCnt_r == WrLast);
  wire logic [6:0] cntNxt   = (bitCnt_r == CntMax) ? bitCnt_r : bitCnt_r + 7'h01;

  wire isRdsr  = (opIn == `BSF_OP_RDSR1);
  wire isRdarg = (opIn == `BSF_OP_RDARG);
  wire isWren  = (opIn == `BSF_OP_WREN);
  wire isWrarg = (opIn == `BSF_OP_WRARG);
  wire opOk    = isRdsr | isRdarg | (!failPub_r & (isWren | isWrarg)); // RL8

  // Read data selection
  wire logic [3:0] rdDec   = nvDecode(addr_r);
  wire             rdVstat = (addr_r == `BSF_ADR_VSTAT);
  wire             rdNv    = rdDec[3] & !failPub_r; // RL10
  wire bsf_byte_t  nvSel   = nvPub_r[rdDec[2:0]];
  wire             rdIsSr  = (opCode_r == `BSF_OP_RDSR1);
  wire             rdIsArg = (opCode_r == `BSF_OP_RDARG);
  wire bsf_byte_t  rdByte  = rdIsSr  ? statusPub_r :
                             rdVstat ? statusPub_r :
                             rdNv    ? nvSel : 8'h00;

  wire rdsrPhase  = rdIsSr & (bitCnt_r > OpLast);
  wire rdargPhase = rdIsArg & (bitCnt_r >= RdStart); // RL9
  wire dataPhase  = rdsrPhase | rdargPhase;

  // Frame decoder, cleared by the frame's own select
  always_ff @(posedge linkClk or posedge linkCsN) begin
    if (linkCsN) begin
      bitCnt_r <= 7'h00;
      shift_r  <= 31'h0000_0000;
      opCode_r <= `BSF_OP_NONE;
      addr_r   <= 32'h0000_0000;
    end else begin
      bitCnt_r <= cntNxt;
      shift_r  <= {shift_r[29:0], linkSi};
      if (opEnd) begin
        opCode_r <= opOk ? opIn : `BSF_OP_NONE; // RL8
      end
      if (addrEnd) begin
        addr_r <= addrIn; // RL9
      end
    end
  end

  // Commands handed to the system clock domain
  wire wrArgOp = (opCode_r == `BSF_OP_WRARG);
  wire wenHit  = opEnd & isWren & !failPub_r;
  wire wrHit   = wrEnd & wrArgOp;

  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      cmdTgl_r  <= 1'b0;
      cmdKind_r <= BSF_CMD_NONE;
      cmdAddr_r <= 32'h0000_0000;
      cmdData_r <= 8'h00;
    end else if (wenHit) begin
      cmdTgl_r  <= ~cmdTgl_r;
      cmdKind_r <= BSF_CMD_WEN;
    end else if (wrHit) begin
      cmdTgl_r  <= ~cmdTgl_r;
      cmdKind_r <= BSF_CMD_WRITE;
      cmdAddr_r <= addr_r;
      cmdData_r <= opIn;
    end
  end

  // Output shifter on the falling edge, single lane only
  wire soBit = rdByte[3'h7 - bitIdx_r];

  always_ff @(negedge linkClk or posedge linkCsN) begin
    if (linkCsN) begin
      so_r     <= 1'b0;
      soEn_r   <= 1'b0;
      bitIdx_r <= 3'h0;
    end else if (dataPhase) begin
      so_r     <= soBit; // RL1
      soEn_r   <= 1'b1;
      bitIdx_r <= bitIdx_r + 3'h1;
    end else begin
      so_r     <= 1'b0;
      soEn_r   <= 1'b0;
    end
  end

  assign linkSo   = so_r;
  assign linkSoEn = soEn_r;

  // System domain
  logic      csMeta_r;
  logic      csIdle_r;
  logic      tglMeta_r;
  logic      tglSync_r;
  logic      tglSeen_r;
  logic      wel_r;
  logic      firstWrDone_r;
  logic      bootFailed_r;
  logic      single_r;
  bsf_byte_t nvReg_r  [NvCount];
  bsf_byte_t nvNxt    [NvCount];

  wire cmdEvt = tglSync_r ^ tglSeen_r;
  wire logic [3:0] wrDec = nvDecode(cmdAddr_r);
  wire cmdIsWen = (cmdKind_r == BSF_CMD_WEN);
  wire cmdIsWr  = (cmdKind_r == BSF_CMD_WRITE);
  wire nvWrite  = cmdEvt & cmdIsWr & wel_r & !st.failed & wrDec[3];
  wire nvFirst  = nvWrite & !firstWrDone_r;
  wire wenSet   = cmdEvt & cmdIsWen & !st.failed;
  wire wrDone   = cmdEvt & cmdIsWr;

  // Frame select synchroniser
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      csMeta_r <= 1'b1;
      csIdle_r <= 1'b1;
    end else begin
      csMeta_r <= linkCsN;
      csIdle_r <= csMeta_r;
    end
  end

  // Command toggle synchroniser and edge memory
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tglMeta_r <= 1'b0;
      tglSync_r <= 1'b0;
      tglSeen_r <= 1'b0;
    end else begin
      tglMeta_r <= cmdTgl_r;
      tglSync_r <= tglMeta_r;
      tglSeen_r <= tglSync_r;
    end
  end

  // Write enable latch
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wel_r <= 1'b0;
    end else if (st.failed || wrDone) begin
      wel_r <= 1'b0; // RL5
    end else if (wenSet) begin
      wel_r <= 1'b1;
    end
  end

  // Nonvolatile registers
  always_comb begin
    for (int i = 0; i < NvCount; i++) begin
      nvNxt[i] = nvReg_r[i];
      if (nvFirst) begin
        nvNxt[i] = nvDefault(3'(i)); // RL14
      end
      if (nvWrite && wrDec[2:0] == 3'(i)) begin
        nvNxt[i] = cmdData_r;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NvCount; i++) begin
        nvReg_r[i] <= nvDefault(3'(i));
      end
      firstWrDone_r <= 1'b0;
    end else begin
      nvReg_r <= nvNxt;
      if (nvWrite) begin
        firstWrDone_r <= 1'b1; // RL14
      end
    end
  end

  assign st.bpSize = nvReg_r[`BSF_STAT_IDX][`BSF_BP_MSB:`BSF_BP_LSB]; // RL7
  assign st.wel    = wel_r;

  // Publish to the link only between frames
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      statusPub_r <= 8'h01;
      failPub_r   <= 1'b0;
    end else if (csIdle_r) begin
      statusPub_r <= st.statusByte;
      failPub_r   <= st.failed;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NvCount; i++) begin
        nvPub_r[i] <= nvDefault(3'(i));
      end
    end else if (csIdle_r) begin
      nvPub_r <= nvReg_r;
    end
  end

  // Failure pin
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bootFailed_r <= 1'b0;
    end else begin
      bootFailed_r <= st.failed;
    end
  end

  // Lane mode, forced to single lane in failure
  wire octalOn = nvReg_r[`BSF_OCT_IDX][`BSF_OCT_BIT];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      single_r <= 1'b1;
    end else begin
      single_r <= st.failed | ~octalOn; // RL1
    end
  end

  assign bootFailed     = bootFailed_r;
  assign singleLaneMode = single_r;
  assign statusView     = statusPub_r;

endmodule : bsf_top

// [sim/bsf_top_chk.sv]
// Port assertions of the boot failure status block
`timescale 1ns/100ps
module bsf_top_chk (
  input wire logic               clk_sys,
  input wire logic               resetn,
  input wire logic               mcuInitFail,
  input wire logic               linkCsN,
  input wire logic               linkSoEn,
  input wire logic               bootFailed,
  input wire logic               singleLaneMode,
  input wire bsf_pkg::bsf_byte_t statusView
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Failure seen and published copy refreshed
  sequence failSettled;
    (bootFailed && linkCsN) [*8];
  endsequence

  prg_err_a: assert property (failSettled |-> statusView[6])
    else $error("program error flag low in failure");
  ers_err_a: assert property (failSettled |-> statusView[5])
    else $error("erase error flag low in failure");
  busy_hold_a: assert property (failSettled |-> statusView[0])
    else $error("busy flag low in failure");
  wel_zero_a: assert property (failSettled |-> !statusView[1])
    else $error("write enable latch set in failure");
  rsv_zero_a: assert property (failSettled |-> !statusView[7])
    else $error("reserved bit set in failure");
  single_lane_a: assert property (bootFailed |-> singleLaneMode)
    else $error("wide mode while failed");
  fail_sticky_a: assert property (bootFailed |=> bootFailed)
    else $error("failure flag dropped");
  fail_cause_a: assert property ($rose(bootFailed) |-> $past(mcuInitFail))
    else $error("failure flag without init failure");
  healthy_sig_a: assert property (!bootFailed |-> !(statusView[6] && statusView[5]))
    else $error("failure signature on healthy device");
  so_idle_a: assert property (linkCsN |-> !linkSoEn)
    else $error("output enable high outside a frame");

  cover property ($rose(bootFailed));
  cover property (failSettled);
  cover property ($rose(linkSoEn));
  cover property ($rose(statusView[1]));
endmodule : bsf_top_chk

bind bsf_top bsf_top_chk chk_i (
  .clk_sys        (clk_sys),
  .resetn         (resetn),
  .mcuInitFail    (mcuInitFail),
  .linkCsN        (linkCsN),
  .linkSoEn       (linkSoEn),
  .bootFailed     (bootFailed),
  .singleLaneMode (singleLaneMode),
  .statusView     (statusView)
);

// [sim/bsf_host.sv]
// Host controller model on the serial register link
`timescale 1ns/100ps
`include "bsf_params.svh"
module bsf_host (
  input  wire logic clk_sys,
  input  wire logic linkSo,
  input  wire logic linkSoEn,
  output logic      linkClk,
  output logic      linkCsN,
  output logic      linkSi
);
  import bsf_pkg::*;
  bsf_byte_t rxByte;
  logic      rxEn;
  event      gotEv;

  initial begin
    linkClk = 1'b0;
    linkCsN = 1'b1;
    linkSi  = 1'b0;
  end

  // Clock toggles only inside a frame
  task automatic frame(input logic [47:0] bits, input int nOut, input bit doRd);
    @(negedge clk_sys);
    #3.7 linkCsN = 1'b0;
    for (int i = 0; i < nOut; i++) begin
      linkSi = bits[47-i];
      #24 linkClk = 1'b1;
      #24 linkClk = 1'b0;
    end
    rxEn = doRd;
    for (int i = 0; i < 8 && doRd; i++) begin
      linkSi = ~linkSi;
      #24 linkClk = 1'b1;
      rxByte = {rxByte[6:0], linkSo};
      rxEn   = rxEn & linkSoEn;
      #24 linkClk = 1'b0;
    end
    #24 linkCsN = 1'b1;
    linkSi = ~linkSi;
    if (doRd) -> gotEv;
    #60;
  endtask : frame

  // Single lane is the narrowest mode, the only one polled
  task automatic rd_status();
    frame({`BSF_OP_RDSR1, 40'h0}, 8, 1'b1);
  endtask : rd_status

  // Four address bytes then two latency cycles
  task automatic rd_reg(input bsf_addr_t a);
    frame({`BSF_OP_RDARG, a, 8'h00}, 42, 1'b1);
  endtask : rd_reg

  task automatic wr_en();
    frame({`BSF_OP_WREN, 40'h0}, 8, 1'b0);
  endtask : wr_en

  task automatic wr_reg(input bsf_addr_t a, input bsf_byte_t d);
    frame({`BSF_OP_WRARG, a, d}, 48, 1'b0);
  endtask : wr_reg
endmodule : bsf_host

// [sim/testbench.sv]
// Self-checking bench of the boot failure status block
`timescale 1ns/100ps
`include "bsf_params.svh"
module testbench;
  import bsf_pkg::*;
  logic      clk_sys;
  logic      resetn;
  logic      mcuInitDone;
  logic      mcuInitFail;
  logic      linkClk;
  logic      linkCsN;
  logic      linkSi;
  logic      linkSo;
  logic      linkSoEn;
  logic      bootFailed;
  logic      singleLaneMode;
  bsf_byte_t statusView;
  bsf_byte_t expQ[$];
  bsf_bp_t   bp;
  int        err_total = 0;
  int        checks_done = 0;
  integer    seed = 32'h8BF3A1B6;

  bsf_top DUT (
    .clk_sys(clk_sys), .resetn(resetn), .mcuInitDone(mcuInitDone),
    .mcuInitFail(mcuInitFail), .linkClk(linkClk), .linkCsN(linkCsN),
    .linkSi(linkSi), .linkSo(linkSo), .linkSoEn(linkSoEn), .bootFailed(bootFailed),
    .singleLaneMode(singleLaneMode), .statusView(statusView)
  );

  bsf_host host (
    .clk_sys(clk_sys), .linkSo(linkSo), .linkSoEn(linkSoEn), .linkClk(linkClk),
    .linkCsN(linkCsN), .linkSi(linkSi)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read results are compared against the oldest note
  always @(host.gotEv) begin
    chk(host.rxByte, (expQ.size() > 0) ? expQ.pop_front() : 8'hEE);
    chk({7'h0, host.rxEn}, 8'h01);
  end

  task automatic rd_exp(input bsf_byte_t e);
    expQ.push_back(e);
    host.rd_status();
  endtask : rd_exp

  task automatic reg_exp(input bsf_addr_t a, input bsf_byte_t e);
    expQ.push_back(e);
    host.rd_reg(a);
  endtask : reg_exp

  task automatic hw_reset(input logic fail);
    @(negedge clk_sys);
    resetn = 1'b0;
    mcuInitFail = fail;
    mcuInitDone = ~fail;
    repeat (16) @(negedge clk_sys);
    chk(statusView, 8'h01);
    chk({7'h0, bootFailed}, 8'h00);
    resetn = 1'b1;
    repeat (10) @(negedge clk_sys);
  endtask : hw_reset

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  initial begin
    #200000;
    err_total++;
    finish_test();
  end

  initial begin
    resetn = 1'b0;
    mcuInitDone = 1'b0;
    mcuInitFail = 1'b0;
    hw_reset(1'b1);
    chk({7'h0, bootFailed}, 8'h01);
    chk({7'h0, singleLaneMode}, 8'h01);
    rd_exp(8'h61);
    host.wr_en();
    rd_exp(8'h61);
    reg_exp(`BSF_ADR_VSTAT, 8'h61);
    host.wr_reg(`BSF_ADR_NVBASE, 8'h1C);
    rd_exp(8'h61);
    hw_reset(1'b0);
    rd_exp(8'h00);
    bp = 3'($random(seed)) | 3'h1;
    host.wr_en();
    rd_exp(8'h02);
    host.wr_reg(`BSF_ADR_NVBASE, {3'h0, bp, 2'h0});
    rd_exp({3'h0, bp, 2'h0});
    reg_exp(`BSF_ADR_NVBASE + 32'h5, `BSF_CFG5_RST);
    reg_exp(`BSF_ADR_NVBASE + 32'h1, `BSF_NV_RST);
    host.wr_reg(`BSF_ADR_NVBASE, 8'h00);
    rd_exp({3'h0, bp, 2'h0});
    host.wr_en();
    host.wr_reg(`BSF_ADR_NVBASE + 32'h2, 8'h01);
    repeat (8) @(negedge clk_sys);
    chk({7'h0, singleLaneMode}, 8'h00);
    chk({7'h0, bootFailed}, 8'h00);
    rd_exp({3'h0, bp, 2'h0});
    reg_exp(`BSF_ADR_NVBASE + 32'h2, 8'h01);
    finish_test();
  end
endmodule : testbench
